//--- verilog/tlvic_pkg.sv
// Constants shared by the two-level vectored interrupt controller
package tlvic_pkg;
   localparam int          NUM_SLOTS      = 15;
   localparam int          IDX_W          = 4;
   // Register addresses on the special function register port
   localparam logic [7:0]  IRQ_ENABLE_ADDR  = 8'ha8;
   localparam logic [7:0]  BASE_PRIO_ADDR   = 8'hb8;
   localparam logic [7:0]  EXT_ENABLE_ADDR  = 8'he6;
   localparam logic [7:0]  EXT_PRIO_ADDR    = 8'hf6;
   // Reset values
   localparam logic [7:0]  IRQ_ENABLE_RST   = 8'h00;
   localparam logic [7:0]  BASE_PRIO_RST    = 8'h80;
   localparam logic [7:0]  EXT_ENABLE_RST   = 8'h00;
   localparam logic [7:0]  EXT_PRIO_RST     = 8'h00;
   // Field positions
   localparam int          GLOBAL_GATE_BIT  = 7;
   localparam int          EXT_RSVD_BIT     = 1;
   localparam int          RSVD_SLOT        = 8;
   localparam int          TIMER2_SLOT      = 5;
   localparam int          EXT0_SLOT        = 0;
   localparam int          TIMER0_SLOT      = 1;
   localparam int          EXT1_SLOT        = 2;
   localparam int          TIMER1_SLOT      = 3;
   // Vector table
   localparam logic [15:0] VECTOR_BASE      = 16'h0003;
   localparam int          VECTOR_STEP_LOG2 = 3;
   localparam logic [15:0] RESET_VECTOR     = 16'h0000;
   // Timing in system clock cycles
   localparam int          LONG_CALL_CYCLES     = 4;
   localparam int          DETECT_CYCLES    = 1;
   // Controller states
   typedef enum logic [1:0] {
      TLVIC_RUN  = 2'b01,
      TLVIC_CALL = 2'b10
   } tlvic_state_t;
endpackage

//--- verilog/tlvic_pick.sv
// Registered two-level priority picker over all vector slots
`timescale 1ns/100ps
module tlvic_pick import tlvic_pkg::*; #(
   parameter int N = NUM_SLOTS
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic [N-1:0]     req,
   input  wire logic [N-1:0]     high,
   output logic                  pick_valid,
   output logic                  pick_high,
   output logic [IDX_W-1:0]      pick_idx
);
   logic [N-1:0]     req_hi;
   logic             any_hi;
   logic [N-1:0]     cand;
   logic [IDX_W-1:0] next_idx;

   // High-level requests win; otherwise all requests compete
   assign req_hi = req & high;
   assign any_hi = |req_hi;
   assign cand   = any_hi ? req_hi : req;

   // Smallest order number wins among equals
   always_comb begin
      next_idx = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (cand[i]) begin
            next_idx = IDX_W'(i);
         end
      end
   end

   // Detection cycle: decode is redone every clock
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pick_valid <= 1'b0;
         pick_high  <= 1'b0;
         pick_idx   <= '0;
      end else begin
         pick_valid <= |req;
         pick_high  <= any_hi;
         pick_idx   <= next_idx;
      end
   end
endmodule

//--- verilog/tlvic_top.sv
// Two-level vectored interrupt controller facing the core sequencer
`timescale 1ns/100ps
module tlvic_top import tlvic_pkg::*; (
   input  wire logic                 clk_sys,
   input  wire logic                 reset_n,
   // Special function register port
   input  wire logic [7:0]           sfr_addr,
   input  wire logic                 sfr_wr,
   input  wire logic [7:0]           sfr_wdata,
   input  wire logic                 sfr_bit_wr,
   input  wire logic [7:0]           sfr_bit_addr,
   input  wire logic                 sfr_bit_val,
   output logic [7:0]                sfr_rdata,
   output logic                      sfr_hit,
   // Peripheral pending flags
   input  wire logic [NUM_SLOTS-1:0] pend_flag,
   input  wire logic                 timer2_low_overflow_flag,
   input  wire logic                 timer2_high_overflow_flag,
   input  wire logic                 ext_input0_edge_mode,
   input  wire logic                 ext_input1_edge_mode,
   output logic [NUM_SLOTS-1:0]      pend_hw_clear,
   // Core sequencer
   input  wire logic                 instr_done,
   input  wire logic                 instr_is_return_from_irq,
   output logic                      long_call,
   output logic [15:0]               irq_vector,
   output logic                      call_busy,
   output logic                      svc_low_active,
   output logic                      svc_high_active
);
   logic                 rst_meta;
   logic                 rst_n;
   logic [7:0]           irq_enable_reg;
   logic [7:0]           base_priority_reg;
   logic [7:0]           ext_irq_enable_reg;
   logic [7:0]           extended_priority_reg;
   tlvic_state_t         state;
   logic [2:0]           call_cnt;
   logic [NUM_SLOTS-1:0] eff_pend;
   logic [NUM_SLOTS-1:0] mask;
   logic [NUM_SLOTS-1:0] high;
   logic [NUM_SLOTS-1:0] gated;
   logic                 pick_valid;
   logic                 pick_high;
   logic [IDX_W-1:0]     pick_idx;
   logic                 preempt_ok;
   logic                 grant;
   logic                 return_from_irq_done;
   logic [NUM_SLOTS-1:0] hw_clr_able;
   logic [NUM_SLOTS-1:0] next_hw_clear;
   logic [15:0]          next_vector;
   logic                 wr_ie;
   logic                 wr_ip;
   logic                 wr_eie;
   logic                 wr_eip;
   logic                 bit_ie;
   logic                 bit_ip;
   logic [7:0]           bit_sel;
   logic [7:0]           rd_mux;
   logic                 rd_hit;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // Write decode; bit writes hit only the two bit-addressable registers
   assign wr_ie   = sfr_wr && (sfr_addr == IRQ_ENABLE_ADDR);
   assign wr_ip   = sfr_wr && (sfr_addr == BASE_PRIO_ADDR);
   assign wr_eie  = sfr_wr && (sfr_addr == EXT_ENABLE_ADDR);
   assign wr_eip  = sfr_wr && (sfr_addr == EXT_PRIO_ADDR);
   assign bit_ie  = sfr_bit_wr && ({sfr_bit_addr[7:3], 3'h0} == IRQ_ENABLE_ADDR);
   assign bit_ip  = sfr_bit_wr && ({sfr_bit_addr[7:3], 3'h0} == BASE_PRIO_ADDR);
   assign bit_sel = 8'h01 << sfr_bit_addr[2:0];

   // Enable register: free read/write, zero at reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_enable_reg <= IRQ_ENABLE_RST;
      end else if (wr_ie) begin
         irq_enable_reg <= sfr_wdata;
      end else if (bit_ie) begin
         irq_enable_reg <= sfr_bit_val ? (irq_enable_reg | bit_sel)
                                       : (irq_enable_reg & ~bit_sel);
      end
   end

   // Priority registers start at low level; the base register's unused top bit reads one
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         base_priority_reg     <= BASE_PRIO_RST;
         extended_priority_reg <= EXT_PRIO_RST;
      end else begin
         if (wr_ip) begin
            base_priority_reg <= sfr_wdata | BASE_PRIO_RST;
         end else if (bit_ip) begin
            base_priority_reg <= (sfr_bit_val ? (base_priority_reg | bit_sel)
                                              : (base_priority_reg & ~bit_sel))
                                 | BASE_PRIO_RST;
         end
         if (wr_eip) begin
            extended_priority_reg <= sfr_wdata;
         end
      end
   end

   // Extended enables; reserved bit held at zero
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ext_irq_enable_reg <= EXT_ENABLE_RST;
      end else if (wr_eie) begin
         ext_irq_enable_reg <= sfr_wdata & ~(8'h01 << EXT_RSVD_BIT);
      end
   end

   // Read mux, registered so the read port settles one clock later
   assign rd_hit = (sfr_addr == IRQ_ENABLE_ADDR) || (sfr_addr == BASE_PRIO_ADDR) ||
                   (sfr_addr == EXT_ENABLE_ADDR) || (sfr_addr == EXT_PRIO_ADDR);
   assign rd_mux = (sfr_addr == IRQ_ENABLE_ADDR) ? irq_enable_reg :
                   (sfr_addr == BASE_PRIO_ADDR)  ? base_priority_reg :
                   (sfr_addr == EXT_ENABLE_ADDR) ? ext_irq_enable_reg :
                   (sfr_addr == EXT_PRIO_ADDR)   ? extended_priority_reg : 8'h00;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sfr_rdata <= 8'h00;
         sfr_hit   <= 1'b0;
      end else begin
         sfr_rdata <= rd_mux;
         sfr_hit   <= rd_hit;
      end
   end

   // Per-slot enables and levels; the reserved slot never requests
   assign mask = {ext_irq_enable_reg[7:2], 1'b0, ext_irq_enable_reg[0],
                  irq_enable_reg[6:0]};
   assign high = {extended_priority_reg[7:2], 1'b0, extended_priority_reg[0],
                  base_priority_reg[6:0]};

   // Either timer 2 overflow raises its request
   always_comb begin
      eff_pend = pend_flag;
      eff_pend[TIMER2_SLOT] = timer2_low_overflow_flag | timer2_high_overflow_flag;
   end

   // Flags are seen whatever the enables; only gated ones request
   assign gated = eff_pend & mask & {NUM_SLOTS{irq_enable_reg[GLOBAL_GATE_BIT]}};

   // Decode every clock; this register is the detection cycle
   tlvic_pick #(
      .N (NUM_SLOTS)
   ) u_pick (
      .clk_sys    (clk_sys),
      .rst_n      (rst_n),
      .req        (gated),
      .high       (high),
      .pick_valid (pick_valid),
      .pick_high  (pick_high),
      .pick_idx   (pick_idx)
   );

   // Preemption: high only over a low routine, nothing over high
   assign preempt_ok = pick_high ? !svc_high_active
                                 : !(svc_low_active || svc_high_active);

   // Grant at an instruction boundary, never on the return itself, so exactly
   // one instruction completes after a return before the call
   assign return_from_irq_done = instr_done && instr_is_return_from_irq;
   assign grant = (state == TLVIC_RUN) && instr_done && !instr_is_return_from_irq &&
                  pick_valid && preempt_ok;

   // Vector address and hardware-cleared flags of the granted slot
   assign next_vector = VECTOR_BASE + (16'(pick_idx) << VECTOR_STEP_LOG2);
   always_comb begin
      hw_clr_able              = '0;
      hw_clr_able[EXT0_SLOT]   = ext_input0_edge_mode;
      hw_clr_able[TIMER0_SLOT] = 1'b1;
      hw_clr_able[EXT1_SLOT]   = ext_input1_edge_mode;
      hw_clr_able[TIMER1_SLOT] = 1'b1;
   end
   assign next_hw_clear = grant ? (hw_clr_able & (15'h0001 << pick_idx)) : '0;

   // Call sequencing: blocks new grants while the core makes the call
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state     <= TLVIC_RUN;
         call_cnt  <= 3'h0;
         call_busy <= 1'b0;
      end else begin
         case (state)
            TLVIC_RUN: begin
               if (grant) begin
                  state     <= TLVIC_CALL;
                  call_cnt  <= 3'(LONG_CALL_CYCLES - 1);
                  call_busy <= 1'b1;
               end
            end
            TLVIC_CALL: begin
               if (call_cnt == 3'h0) begin
                  state     <= TLVIC_RUN;
                  call_busy <= 1'b0;
               end else begin
                  call_cnt <= call_cnt - 3'h1;
               end
            end
            default: begin
               state     <= TLVIC_RUN;
               call_busy <= 1'b0;
            end
         endcase
      end
   end

   // Call strobe, vector and flag clears, all one-cycle from grant
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         long_call     <= 1'b0;
         irq_vector    <= RESET_VECTOR;
         pend_hw_clear <= '0;
      end else begin
         long_call     <= grant;
         pend_hw_clear <= next_hw_clear;
         if (grant) begin
            irq_vector <= next_vector;
         end
      end
   end

   // In-service levels; a return ends the highest active level
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         svc_low_active  <= 1'b0;
         svc_high_active <= 1'b0;
      end else begin
         if (grant && pick_high) begin
            svc_high_active <= 1'b1;
         end else if (grant) begin
            svc_low_active <= 1'b1;
         end else if (return_from_irq_done && svc_high_active) begin
            svc_high_active <= 1'b0;
         end else if (return_from_irq_done) begin
            svc_low_active <= 1'b0;
         end
      end
   end
endmodule

//--- verif/tlvic_chk.sv
// Assertion checker bound to the interrupt controller top
`timescale 1ns/100ps
module tlvic_chk import tlvic_pkg::*; (
   input wire logic                 clk_sys,
   input wire logic                 reset_n,
   input wire logic [7:0]           sfr_addr,
   input wire logic                 sfr_wr,
   input wire logic [7:0]           sfr_wdata,
   input wire logic                 sfr_bit_wr,
   input wire logic [7:0]           sfr_bit_addr,
   input wire logic                 sfr_bit_val,
   input wire logic [7:0]           sfr_rdata,
   input wire logic                 sfr_hit,
   input wire logic [NUM_SLOTS-1:0] pend_hw_clear,
   input wire logic                 instr_done,
   input wire logic                 instr_is_return_from_irq,
   input wire logic                 long_call,
   input wire logic [15:0]          irq_vector,
   input wire logic                 call_busy,
   input wire logic                 svc_low_active,
   input wire logic                 svc_high_active
);
   logic [7:0] gate_sh;
   logic       prev_return_from_irq;
   // Enable shadow; byte write wins, last completion remembered
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         gate_sh   <= IRQ_ENABLE_RST;
         prev_return_from_irq <= 1'b0;
      end else begin
         if (sfr_wr && sfr_addr == IRQ_ENABLE_ADDR)
            gate_sh <= sfr_wdata;
         else if (sfr_bit_wr && sfr_bit_addr[7:3] == IRQ_ENABLE_ADDR[7:3])
            gate_sh[sfr_bit_addr[2:0]] <= sfr_bit_val;
         if (instr_done)
            prev_return_from_irq <= instr_is_return_from_irq;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   AST_CALL_LEN: assert property (
      long_call |-> call_busy [*4] ##1 !call_busy) else $error("call length wrong");
   AST_GATE: assert property (
      long_call |-> $past(gate_sh[7], 2)) else $error("call with gate off");
   AST_MASK: assert property (
      long_call && irq_vector < 16'h0038 |->
      |($past(gate_sh, 2) & (8'h01 << irq_vector[5:3]))) else $error("masked source called");
   AST_VEC: assert property (
      long_call |-> irq_vector[2:0] == 3'h3 && irq_vector <= 16'h0073
      && irq_vector != 16'h0043) else $error("bad vector");
   AST_AFTER_DONE: assert property (
      long_call |-> $past(instr_done) && !$past(call_busy)) else $error("call not at done");
   AST_HOLD: assert property (
      long_call |-> $past(instr_done) && !$past(instr_is_return_from_irq)) else $error("no step after return");
   AST_HIGH: assert property (
      long_call |-> !$past(svc_high_active)) else $error("high routine preempted");
   AST_LOW_WAIT: assert property (
      long_call && $past(svc_low_active) |-> svc_high_active && !$past(svc_high_active))
      else $error("low routine preempted by equal");
   AST_HWCLR: assert property (
      |pend_hw_clear |-> long_call && pend_hw_clear[14:4] == 11'h000) else $error("bad clear");
   AST_RD: assert property (
      $past(reset_n, 3) && $past(sfr_addr) == IRQ_ENABLE_ADDR |->
      sfr_hit && sfr_rdata == $past(gate_sh)) else $error("enable readback wrong");
   COV_PREEMPT: cover property (long_call && svc_low_active && svc_high_active);
   COV_RETURN_FROM_IRQ: cover property (instr_done && instr_is_return_from_irq);
   COV_T2: cover property (long_call && irq_vector == 16'h002b);
   // Call right after the single step that follows a return
   COV_AFTER_RET: cover property (long_call && $past(prev_return_from_irq));
endmodule
bind tlvic_top tlvic_chk u_tlvic_chk (.clk_sys, .reset_n, .sfr_addr, .sfr_wr, .sfr_wdata,
   .sfr_bit_wr, .sfr_bit_addr, .sfr_bit_val, .sfr_rdata, .sfr_hit, .pend_hw_clear,
   .instr_done, .instr_is_return_from_irq, .long_call, .irq_vector, .call_busy, .svc_low_active,
   .svc_high_active);

//--- verif/tlvic_core_model.sv
// Core sequencer and pending flag model for the controller
`timescale 1ns/100ps
module tlvic_core_model import tlvic_pkg::*; (
   input  wire logic                 clk_sys,
   input  wire logic                 reset_n,
   input  wire logic [NUM_SLOTS-1:0] flag_set,
   input  wire logic [NUM_SLOTS-1:0] flag_clr,
   input  wire logic [NUM_SLOTS-1:0] pend_hw_clear,
   input  wire logic [3:0]           instr_len,
   input  wire logic                 return_from_irq_req,
   input  wire logic                 call_busy,
   output logic [NUM_SLOTS-1:0]      pend_flag,
   output logic                      instr_done,
   output logic                      instr_is_return_from_irq
);
   logic [3:0] cnt;
   logic       used;
   // Length zero halts; core stalls while the call runs
   wire        fire = instr_len != 4'h0 && !call_busy && cnt >= instr_len - 4'h1;
   // One return per request, so the next completion is a plain step
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pend_flag     <= '0;
         cnt           <= 4'h0;
         used          <= 1'b0;
         instr_done    <= 1'b0;
         instr_is_return_from_irq <= 1'b0;
      end else begin
         pend_flag     <= (pend_flag | flag_set) & ~flag_clr & ~pend_hw_clear & ~15'h0120;
         cnt           <= (fire || call_busy) ? 4'h0 : cnt + 4'h1;
         instr_done    <= fire;
         instr_is_return_from_irq <= fire && return_from_irq_req && !used;
         used          <= return_from_irq_req && (used || fire);
      end
   end
endmodule

//--- verif/tb.sv
// Self-checking testbench for the interrupt controller
`timescale 1ns/100ps
module tb;
   import tlvic_pkg::*;
   logic                 clk_sys, reset_n, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_hit;
   logic [7:0]           sfr_addr, sfr_wdata, sfr_bit_addr, sfr_rdata;
   logic [NUM_SLOTS-1:0] pend_flag, pend_hw_clear, flag_set, flag_clr;
   logic                 t2_lo, t2_hi, instr_done, instr_is_return_from_irq, return_from_irq_req;
   logic                 long_call, call_busy, svc_low_active, svc_high_active;
   logic [15:0]          irq_vector;
   logic [3:0]           instr_len;
   int                   miscompares = 0, checked = 0, ncall = 0, n;
   tlvic_top u_tlvic_top (.clk_sys, .reset_n, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_bit_wr,
      .sfr_bit_addr, .sfr_bit_val, .sfr_rdata, .sfr_hit, .pend_flag,
      .timer2_low_overflow_flag(t2_lo), .timer2_high_overflow_flag(t2_hi),
      .ext_input0_edge_mode(1'b0), .ext_input1_edge_mode(1'b1), .pend_hw_clear,
      .instr_done, .instr_is_return_from_irq, .long_call, .irq_vector, .call_busy, .svc_low_active,
      .svc_high_active);
   tlvic_core_model u_tlvic_core_model (.clk_sys, .reset_n, .flag_set, .flag_clr,
      .pend_hw_clear, .instr_len, .return_from_irq_req, .call_busy, .pend_flag, .instr_done,
      .instr_is_return_from_irq);
   always #25 clk_sys = ~clk_sys;
   // Count calls so refusals can be seen
   always @(posedge clk_sys) if (long_call === 1'b1) ncall++;
   task automatic cyc(input int k = 1);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input string nm, input logic [15:0] got, exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic b, input logic [7:0] a, d);
      sfr_addr = a;
      sfr_bit_addr = a;
      sfr_wdata = d;
      sfr_bit_val = d[0];
      sfr_wr = !b;
      sfr_bit_wr = b;
      cyc();
      sfr_wr = 1'b0;
      sfr_bit_wr = 1'b0;
      cyc();
   endtask
   task automatic rd(input logic [7:0] a, input logic [8:0] exp);
      sfr_addr = a;
      cyc();
      chk("sfr read", {7'h00, sfr_hit, sfr_rdata}, {7'h00, exp});
   endtask
   // Never entered twice in one step; strobes drop after one edge
   task automatic fl(input logic [14:0] m, input logic v);
      flag_set = v ? m : 15'h0000;
      flag_clr = v ? 15'h0000 : m;
      cyc();
      flag_set = 15'h0000;
      flag_clr = 15'h0000;
   endtask
   task automatic wcall(input logic [15:0] v);
      n = 0;
      while (long_call !== 1'b1 && n < 60) begin
         cyc();
         n++;
      end
      chk("vector", irq_vector, v);
   endtask
   task automatic return_from_irq(input logic [15:0] v, input int k);
      int d;
      int seen;
      int t;
      d = 0;
      seen = 0;
      t = 0;
      cyc(5);
      return_from_irq_req = 1'b1;
      while (!(instr_done === 1'b1 && instr_is_return_from_irq === 1'b1) && d < 40) begin
         cyc();
         d++;
      end
      cyc();
      return_from_irq_req = 1'b0;
      if (k > 0) begin
         while (long_call !== 1'b1 && d < 80) begin
            if (instr_done === 1'b1) seen++;
            cyc();
            d++;
            t++;
         end
         chk("steps after return", 16'(seen), 16'(k));
         chk("return latency", 16'(t + 1), 16'h0002);
         chk("vector", irq_vector, v);
      end
   endtask
   task automatic t_regs();
      rd(IRQ_ENABLE_ADDR, 9'h100);
      rd(BASE_PRIO_ADDR, 9'h180);
      rd(8'h10, 9'h000);
      wr(1'b0, IRQ_ENABLE_ADDR, 8'h5a);
      wr(1'b1, 8'haf, 8'h01);
      rd(IRQ_ENABLE_ADDR, 9'h1da);
      wr(1'b0, BASE_PRIO_ADDR, 8'h00);
      rd(BASE_PRIO_ADDR, 9'h180);
      $display("register test done");
   endtask
   task automatic t_gate();
      int c;
      instr_len = 4'h1;
      wr(1'b0, IRQ_ENABLE_ADDR, 8'h02);
      c = ncall;
      fl(15'h0002, 1'b1);
      cyc(20);
      chk("calls with gate off", 16'(ncall), 16'(c));
      chk("flag kept", pend_flag[1], 1'b1);
      wr(1'b1, 8'haf, 8'h01);
      wcall(16'h000b);
      cyc();
      chk("hw clear", pend_flag[1], 1'b0);
      return_from_irq(16'h0000, 0);
      fl(15'h0002, 1'b1);
      wcall(16'h000b);
      chk("fast response", 16'(n), 16'h0002);
      c = 0;
      while (call_busy === 1'b1 && c < 9) begin
         cyc();
         c++;
      end
      chk("call cycles", 16'(c), 16'h0004);
      return_from_irq(16'h0000, 0);
      $display("gate test done");
   endtask
   task automatic t_prio();
      instr_len = 4'h0;
      wr(1'b0, BASE_PRIO_ADDR, 8'h10);
      wr(1'b0, IRQ_ENABLE_ADDR, 8'h9c);
      fl(15'h001c, 1'b1);
      instr_len = 4'h1;
      wcall(16'h0023);
      chk("high active", svc_high_active, 1'b1);
      fl(15'h0010, 1'b0);
      return_from_irq(16'h0013, 1);
      return_from_irq(16'h001b, 1);
      return_from_irq(16'h0000, 0);
      $display("priority test done");
   endtask
   task automatic t_preempt();
      int c;
      wr(1'b0, BASE_PRIO_ADDR, 8'h41);
      wr(1'b0, IRQ_ENABLE_ADDR, 8'hc9);
      fl(15'h0008, 1'b1);
      wcall(16'h001b);
      cyc(5);
      fl(15'h0040, 1'b1);
      wcall(16'h0033);
      chk("both levels", {svc_low_active, svc_high_active}, 2'b11);
      cyc(5);
      c = ncall;
      fl(15'h0001, 1'b1);
      cyc(20);
      chk("high not preempted", 16'(ncall), 16'(c));
      fl(15'h0040, 1'b0);
      return_from_irq(16'h0003, 1);
      cyc();
      chk("level flag kept", pend_flag[0], 1'b1);
      return_from_irq(16'h0003, 1);
      fl(15'h0001, 1'b0);
      return_from_irq(16'h0000, 0);
      return_from_irq(16'h0000, 0);
      $display("preemption test done");
   endtask
   task automatic t_timer2();
      wr(1'b0, IRQ_ENABLE_ADDR, 8'ha0);
      for (int i = 0; i < 2; i++) begin
         t2_lo = (i == 0);
         t2_hi = (i == 1);
         wcall(16'h002b);
         t2_lo = 1'b0;
         t2_hi = 1'b0;
         return_from_irq(16'h0000, 0);
      end
      $display("timer 2 test done");
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Hang guard, far beyond the few hundred cycles needed
   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      test_done();
   end
   initial begin
      clk_sys = 1'b0;
      reset_n = 1'b0;
      {sfr_wr, sfr_bit_wr, sfr_bit_val, t2_lo, t2_hi, return_from_irq_req} = 6'h00;
      {sfr_addr, sfr_wdata, sfr_bit_addr} = 24'h000000;
      {flag_set, flag_clr} = 30'h00000000;
      instr_len = 4'h0;
      cyc(16);
      reset_n = 1'b1;
      cyc(3);
      t_regs();
      t_gate();
      t_prio();
      t_preempt();
      t_timer2();
      test_done();
   end
endmodule
